// ==== pmsi_status_irq.sv ====
// status and interrupt logic of the power management unit: live power-good
// and comparator status, enable mask, interrupt pin, fault reset and start-up.
// assumes register requests come from the serial decoder on clk_i, and that
// the analog monitors and the reset pin are asynchronous to clk_i.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - status bits live, unlatched, unchanged by reads
// - detected condition sets status bit, asserts pin
// - exactly five sources: three bucks, LDO, comparator
// - power-good sets above 90%, clears below 85%
// - status read never releases interrupt pin
// - one enable bit per source, one enables
// - threshold code, 31 mV steps, resets 0x19
// - polarity zero: pin low while comparator above
// - polarity one: pin high while comparator above
// - comparator control bit doubles falling hysteresis
// - overvoltage disables regulators, resets all registers
// - overvoltage release runs power-up then active
// - thermal shutdown resets, restarts with defaults
// - external reset low returns all registers default
// - undervoltage resets registers, then power-up sequence
module pmsi_status_irq
    import pmsi_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int STEP_CYCLES    = STEP_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire pmsi_pins_t            pins_i,
    input  wire pmsi_req_t             req_i,
    output logic       [7:0]           reg_rdata_o,
    output logic                       irq_o,
    output logic       [CODE_W-1:0]    comp_code_o,
    output logic                       comp_hyst_double_o,
    output logic                       ldo_sleep_o,
    output logic       [NUM_REG-1:0]   reg_enable_o,
    output logic                       active_o
);

    localparam int PW = $bits(pmsi_pins_t);
    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] STEP_LAST    = CNT_W'(STEP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PW-1:0]        pin_meta;
    logic [PW-1:0]        pin_sync;
    pmsi_pins_t           pins;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (ce_i) begin
            pin_meta <= pins_i;
            pin_sync <= pin_meta;
        end
    end
    assign pins = pmsi_pins_t'(pin_sync);
    // the cleared synchroniser reads as ext_reset_n low, so the registers stay at their
    // defaults for two more edges after srst_i; nothing else notices

    ////////////////////////////////////////////////////////////////////////////
    // fault reset: any of these holds the control registers and the sequencer at their defaults
    wire fault_any = pins.overvoltage_lockout | pins.thermal_shutdown |
                     pins.undervoltage_lockout | ~pins.ext_reset_n;
    // a fault waits for ce_i, so a freeze really holds every flop
    wire clear_all = srst_i | (ce_i & fault_any);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]           comp_ctrl;
    logic [7:0]           irq_enable;
    logic [7:0]           sleep_pol;
    logic [NUM_SRC-1:0]   status;
    logic [NUM_REG-1:0]   pg_flag;

    wire wr_comp  = req_i.wr && (req_i.addr == ADDR_COMP_CTRL);
    wire wr_en    = req_i.wr && (req_i.addr == ADDR_IRQ_ENABLE);
    wire wr_pol   = req_i.wr && (req_i.addr == ADDR_SLEEP_POL);

    always_ff @(posedge clk_i) begin
        if (clear_all) begin
            comp_ctrl  <= COMP_CTRL_RST;
            irq_enable <= IRQ_ENABLE_RST;
            sleep_pol  <= SLEEP_POL_RST;
        end else if (ce_i) begin
            if (wr_comp)
                comp_ctrl <= req_i.wdata;
            if (wr_en)
                irq_enable <= {3'h0, req_i.wdata[NUM_SRC-1:0]};
            if (wr_pol)
                sleep_pol <= {6'h00, req_i.wdata[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // live status; hysteresis between the two analog thresholds
    // the flag holds between 85 % and 90 %, so it only moves on a full crossing
    wire [NUM_REG-1:0] next_pg_flag = pins.pg_rise | (pg_flag & pins.pg_fall);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pg_flag <= '0;
            status  <= '0;
        end else if (ce_i) begin
            pg_flag <= next_pg_flag;
            status  <= {pins.comp_above, next_pg_flag};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; reads have no side effect on status or pin
    // reg_rdata_o holds the last answer until the next read, so the decoder may take it late
    logic [7:0] rd_mux;
    always_comb begin
        case (req_i.addr)
            ADDR_COMP_CTRL:  rd_mux = comp_ctrl;
            ADDR_IRQ_ENABLE: rd_mux = irq_enable;
            ADDR_IRQ_STATUS: rd_mux = {3'h0, status};
            ADDR_SLEEP_POL:  rd_mux = sleep_pol;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else if (ce_i && req_i.rd)
            reg_rdata_o <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt pin: level only, no latch, so a read cannot release it
    wire irq_any  = |(status & irq_enable[NUM_SRC-1:0]);
    wire polarity = sleep_pol[POL_BIT];
    wire next_irq = polarity ? irq_any : ~irq_any;

    always_ff @(posedge clk_i) begin
        if (srst_i)
            irq_o <= 1'b1;
        else if (ce_i)
            irq_o <= next_irq;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            comp_code_o        <= COMP_CTRL_RST[CODE_W-1:0];
            comp_hyst_double_o <= 1'b0;
            ldo_sleep_o        <= 1'b0;
        end else if (ce_i) begin
            comp_code_o        <= comp_ctrl[CODE_W-1:0];
            comp_hyst_double_o <= comp_ctrl[HYST_DBL_BIT];
            ldo_sleep_o        <= sleep_pol[LDO_SLEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up sequencer: delay, then LDO, buck1, buck2, buck3 a step apart
    // one counter serves delay and steps; any fault restarts the whole sequence
    pmsi_state_t          state;
    pmsi_state_t          next_state;
    logic [CNT_W-1:0]     cnt;
    logic [1:0]           stage;

    wire startup_done = (cnt == STARTUP_LAST);
    wire step_done    = (cnt == STEP_LAST);

    always_comb begin
        case (state)
            ST_RESET:  next_state = ST_DELAY;
            ST_DELAY:  next_state = startup_done ? ST_STEP : ST_DELAY;
            ST_STEP:   next_state = (step_done && stage == 2'd3) ? ST_ACTIVE : ST_STEP;
            ST_ACTIVE: next_state = ST_ACTIVE;
            default:   next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (clear_all) begin
            state        <= ST_RESET;
            cnt          <= '0;
            stage        <= 2'd0;
            reg_enable_o <= '0;
            active_o     <= 1'b0;
        end else if (ce_i) begin
            state    <= next_state;
            active_o <= (next_state == ST_ACTIVE);
            case (state)
                ST_DELAY: begin
                    cnt <= startup_done ? '0 : cnt + 1'b1;
                    if (startup_done)
                        reg_enable_o[SRC_LDO] <= 1'b1;
                end
                ST_STEP: begin
                    cnt <= step_done ? '0 : cnt + 1'b1;
                    if (step_done && stage != 2'd3) begin
                        stage <= stage + 2'd1;
                        reg_enable_o[stage] <= 1'b1;
                    end
                end
                default: cnt <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    property p_status_live;
        ce_i && $past(ce_i) |-> status[SRC_COMP] == $past(pins.comp_above);
    endproperty
    a_status_live: assert property (p_status_live) else $error("status not live");

    property p_irq_follows;
        ce_i && $past(ce_i) |-> irq_o == ($past(polarity) ? $past(irq_any) : !$past(irq_any));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq pin wrong");

    property p_read_no_release;
        req_i.rd && irq_any && polarity && ce_i ##1 irq_any && ce_i |=> irq_o;
    endproperty
    a_read_no_release: assert property (p_read_no_release) else $error("read released pin");

    property p_pg_hold;
        ce_i && pg_flag[0] && pins.pg_fall[0] |=> pg_flag[0];
    endproperty
    a_pg_hold: assert property (p_pg_hold) else $error("power-good dropped early");

    property p_pg_clear;
        ce_i && !pins.pg_fall[0] && !pins.pg_rise[0] |=> !pg_flag[0];
    endproperty
    a_pg_clear: assert property (p_pg_clear) else $error("power-good stuck");

    property p_fault_defaults;
        ce_i && fault_any |=> comp_ctrl == COMP_CTRL_RST && irq_enable == IRQ_ENABLE_RST
            && reg_enable_o == '0 && state == ST_RESET;
    endproperty
    a_fault_defaults: assert property (p_fault_defaults) else $error("fault not reset");

    property p_powerup;
        $rose(reg_enable_o[SRC_LDO]) |-> $past(state) == ST_DELAY && reg_enable_o[2:0] == 3'h0;
    endproperty
    a_powerup: assert property (p_powerup) else $error("LDO enabled out of order");

    property p_enable_write;
        ce_i && wr_en && !fault_any |=> irq_enable[NUM_SRC-1:0] == $past(req_i.wdata[4:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_code_out;
        ce_i && $past(ce_i) |-> comp_code_o == $past(comp_ctrl[CODE_W-1:0])
            && comp_hyst_double_o == $past(comp_ctrl[HYST_DBL_BIT]);
    endproperty
    a_code_out: assert property (p_code_out) else $error("comparator control not driven");

    // pin sense checked on the comparator source alone, so a swapped polarity
    // decode cannot hide behind the generic follow check above
    property p_pol_low;
        ce_i && !polarity && status[SRC_COMP] && irq_enable[SRC_COMP] |=> !irq_o;
    endproperty
    a_pol_low: assert property (p_pol_low) else $error("pin not low for comparator");

    property p_pol_high;
        ce_i && polarity && status[SRC_COMP] && irq_enable[SRC_COMP] |=> irq_o;
    endproperty
    a_pol_high: assert property (p_pol_high) else $error("pin not high for comparator");

    property p_mask_idle;
        ce_i && !polarity && (status & irq_enable[NUM_SRC-1:0]) == 5'h00 |=> irq_o;
    endproperty
    a_mask_idle: assert property (p_mask_idle) else $error("masked source drove pin");

    property p_buck1_order;
        $rose(reg_enable_o[SRC_BUCK1]) |-> reg_enable_o[SRC_LDO] && !reg_enable_o[SRC_BUCK2];
    endproperty
    a_buck1_order: assert property (p_buck1_order) else $error("buck1 out of order");

    property p_active_all;
        $rose(active_o) |-> reg_enable_o == {NUM_REG{1'b1}};
    endproperty
    a_active_all: assert property (p_active_all) else $error("active before all on");

    property p_fault_idle;
        ce_i && fault_any |=> !active_o && sleep_pol == SLEEP_POL_RST;
    endproperty
    a_fault_idle: assert property (p_fault_idle) else $error("fault left block active");

    property p_ext_reset;
        ce_i && !pins.ext_reset_n |=> comp_ctrl == COMP_CTRL_RST && irq_enable == IRQ_ENABLE_RST
            && sleep_pol == SLEEP_POL_RST;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("reset pin kept settings");

    c_active:    cover property (state == ST_STEP ##1 state == ST_ACTIVE);
    c_irq_high:  cover property (polarity && irq_o);
    c_fault:     cover property (state == ST_ACTIVE ##1 fault_any);
    c_pg_hyst:   cover property (pg_flag[1] && !pins.pg_rise[1] && pins.pg_fall[1]);
    c_read_irq:  cover property (req_i.rd && irq_any && polarity);

endmodule

// ==== pmsi_pkg.sv ====
// package of the power status and interrupt block: register map, field layout,
// reset values, state codes and timing counts.
// assumes a 200 MHz core clock and the serial decoder on the same clock.
package pmsi_pkg;

    localparam int          CLK_MHZ           = 200;
    localparam int          STARTUP_DELAY_US  = 15000;
    localparam int          STEP_DELAY_US     = 2000;
    localparam int          STARTUP_CYC       = STARTUP_DELAY_US * CLK_MHZ;
    localparam int          STEP_CYC          = STEP_DELAY_US * CLK_MHZ;
    localparam int          CNT_W             = 22;

    localparam logic [7:0]  ADDR_COMP_CTRL    = 8'h0b;
    localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h0d;
    localparam logic [7:0]  ADDR_SLEEP_POL    = 8'h0e;

    localparam int          NUM_SRC           = 5;
    localparam int          NUM_REG           = 4;
    localparam int          SRC_BUCK1         = 0;
    localparam int          SRC_BUCK2         = 1;
    localparam int          SRC_BUCK3         = 2;
    localparam int          SRC_LDO           = 3;
    localparam int          SRC_COMP          = 4;

    localparam int          CODE_W            = 7;
    localparam int          HYST_DBL_BIT      = 7;
    localparam int          POL_BIT           = 0;
    localparam int          LDO_SLEEP_BIT     = 1;

    localparam logic [7:0]  COMP_CTRL_RST     = 8'h19;
    localparam logic [7:0]  IRQ_ENABLE_RST    = 8'h10;
    localparam logic [7:0]  SLEEP_POL_RST     = 8'h00;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_DELAY  = 2'b01,
        ST_STEP   = 2'b10,
        ST_ACTIVE = 2'b11
    } pmsi_state_t;

    // analog monitors; pg_rise = output above 90 %, pg_fall = output above 85 %
    typedef struct packed {
        logic [NUM_REG-1:0] pg_rise;
        logic [NUM_REG-1:0] pg_fall;
        logic               comp_above;
        logic               overvoltage_lockout;
        logic               thermal_shutdown;
        logic               undervoltage_lockout;
        logic               ext_reset_n;
    } pmsi_pins_t;

    typedef struct packed {
        logic               wr;
        logic               rd;
        logic [7:0]         addr;
        logic [7:0]         wdata;
    } pmsi_req_t;

endpackage

// ==== pmsi_host_model.sv ====
// host side of the serial register port: issues single writes and reads.
// assumes the block takes a request on the rising edge where wr or rd is high.
`timescale 1ns/1ps
module pmsi_host_model
    import pmsi_pkg::*;
(
    input  wire logic clk_i,
    output pmsi_req_t req_o
);
    initial req_o = '0;
    // one request in two cycles, so read answers never overlap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        req_o <= '0;
    endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench of the power status and interrupt block.
// assumes short power-up counts (20 and 5); the clock enable drops once, for a freeze check.
`timescale 1ns/1ps
module tb_top
    import pmsi_pkg::*;
    ;
    logic       clk, srst_i, ce_i, irq, sleep, hyst, active, rd_d1, rd_d2;
    pmsi_pins_t pins;
    pmsi_req_t  req;
    logic [7:0] rdata;
    logic [6:0] code;
    logic [3:0] en;
    logic [31:0] r;
    int         err_count, n_tests, cyc, seed;
    logic [7:0] exp_q[$];

    pmsi_host_model i_host (.clk_i(clk), .req_o(req));
    pmsi_status_irq #(.STARTUP_CYCLES(20), .STEP_CYCLES(5)) i_dut (
        .clk_i(clk), .srst_i(srst_i), .ce_i(ce_i), .pins_i(pins), .req_i(req),
        .reg_rdata_o(rdata), .irq_o(irq), .comp_code_o(code),
        .comp_hyst_double_o(hyst), .ldo_sleep_o(sleep), .reg_enable_o(en),
        .active_o(active));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        err_count += exp_q.size();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic ws(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask
    // read at the fourth edge, before its updates, so stimulus stays on edges
    task automatic pin(input logic e);
        ws(4);
        check({7'h00, irq}, {7'h00, e});
    endtask
    task automatic hp(input logic [3:0] rs, input logic [3:0] fl);
        pins.pg_rise <= rs;
        pins.pg_fall <= fl;
        ws(6);
    endtask
    task automatic src(input logic [3:0] pg, input logic c);
        pins.comp_above <= c;
        hp(pg, pg);
    endtask
    task automatic up();
        int k;
        k = 0;
        while (active !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        check({3'h0, active, en}, 8'h1f);
    endtask
    // the read answer stands from one cycle after the rd edge
    always @(posedge clk) begin
        rd_d1 <= req.rd;
        rd_d2 <= rd_d1;
        if (rd_d2 && exp_q.size() > 0) check(rdata, exp_q.pop_front());
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    ////////////////////////////////////////
    initial begin
        seed = 36195;
        srst_i = 1'b1;
        ce_i = 1'b1;
        pins = 13'h0001;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        ws(3);
        srst_i <= 1'b0;
        ws(3);
        rx(ADDR_COMP_CTRL, 8'h19);
        rx(ADDR_IRQ_ENABLE, 8'h10);
        rx(ADDR_SLEEP_POL, 8'h00);
        rx(8'h20, 8'h00);
        up();
        for (int k = 0; k < NUM_SRC; k++) begin
            i_host.wr(ADDR_IRQ_ENABLE, 8'h01 << k);
            src(k < 4 ? 4'h1 << k : 4'h0, k == 4);
            rx(ADDR_IRQ_STATUS, 8'h01 << k);
            rx(ADDR_IRQ_STATUS, 8'h01 << k);
            pin(1'b0);
            i_host.wr(ADDR_IRQ_ENABLE, ~(8'h01 << k));
            pin(1'b1);
            rx(ADDR_IRQ_ENABLE, 8'h1f & ~(8'h01 << k));
            src(4'h0, 1'b0);
        end
        i_host.wr(ADDR_IRQ_ENABLE, 8'h1f);
        repeat (8) begin
            r = $random(seed);
            src(r[3:0], r[4]);
            rx(ADDR_IRQ_STATUS, {3'h0, r[4:0]});
            pin(r[4:0] == 5'h00);
        end
        src(4'h0, 1'b0);
        hp(4'h0, 4'h1);
        rx(ADDR_IRQ_STATUS, 8'h00);
        hp(4'h1, 4'h1);
        hp(4'h0, 4'h1);
        rx(ADDR_IRQ_STATUS, 8'h01);
        hp(4'h0, 4'h0);
        rx(ADDR_IRQ_STATUS, 8'h00);
        i_host.wr(ADDR_SLEEP_POL, 8'h03);
        rx(ADDR_SLEEP_POL, 8'h03);
        src(4'h0, 1'b1);
        rx(ADDR_IRQ_STATUS, 8'h10);
        pin(1'b1);
        check({7'h00, sleep}, 8'h01);
        src(4'h0, 1'b0);
        pin(1'b0);
        i_host.wr(ADDR_COMP_CTRL, 8'h85);
        i_host.wr(ADDR_IRQ_STATUS, 8'hff);
        check({hyst, code}, 8'h85);
        rx(ADDR_IRQ_STATUS, 8'h00);
        for (int f = 0; f < 4; f++) begin
            i_host.wr(ADDR_COMP_CTRL, 8'h7f);
            {pins.overvoltage_lockout, pins.thermal_shutdown,
             pins.undervoltage_lockout, pins.ext_reset_n} <= 4'b0001 ^ (4'b1000 >> f);
            ws(6);
            check({3'h0, active, en}, 8'h00);
            rx(ADDR_COMP_CTRL, 8'h19);
            {pins.overvoltage_lockout, pins.thermal_shutdown,
             pins.undervoltage_lockout, pins.ext_reset_n} <= 4'b0001;
            up();
            rx(ADDR_IRQ_ENABLE, 8'h10);
        end
        ce_i <= 1'b0;
        src(4'h0, 1'b1);
        pin(1'b1);
        check({3'h0, active, en}, 8'h1f);
        ce_i <= 1'b1;
        src(4'h0, 1'b1);
        pin(1'b0);
        ws(4);
        complete_run();
    end
endmodule
